//--- hw/dispense_io_pkg.sv
// constants, carriers and state types of the discrete io supervisor
// assumes a 10 MHz aclk and a 32-bit axi4-lite register bus
package dispense_io_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam longint      SOAK_UNIT_NS   = 64'd60_000_000_000;
    localparam int unsigned SOAK_UNIT_CYC  =
        int'(SOAK_UNIT_NS / longint'(CLK_PERIOD_NS));
    localparam int unsigned FILTER_NS      = 400;
    localparam int unsigned FILTER_CYC     =
        (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FILTER_CNT_W   = 3;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_LOCAL      = 8'h04;
    localparam logic [7:0] OFS_SOAK       = 8'h08;
    localparam logic [7:0] OFS_STATUS     = 8'h0C;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_EN     = 8'h14;
    localparam logic [7:0] OFS_INT_CLR    = 8'h18;
    localparam logic [7:0] OFS_TEMP_BASE  = 8'h20;
    localparam int unsigned NUM_ZONES     = 4;

    // temperature fields, degrees F
    localparam int unsigned TEMP_W        = 9;
    localparam int unsigned SP_LSB        = 0;
    localparam int unsigned SB_LSB        = 16;
    localparam logic [8:0]  SETBACK_GAP   = 9'h014;
    localparam logic [8:0]  SP_RST        = 9'h17C;
    localparam logic [8:0]  SB_RST        = 9'h12C;

    // soak length in minutes
    localparam logic [15:0] SOAK_MIN_RST  = 16'h002D;

    // interrupt event positions
    localparam int unsigned EV_ALARM      = 0;
    localparam int unsigned EV_EMPTY      = 1;
    localparam int unsigned EV_READY      = 2;
    localparam int unsigned EV_TAKEOVER   = 3;
    localparam int unsigned EV_CROSS      = 4;
    localparam int unsigned EV_W          = 5;

    // axi responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic takeover;
        logic pump;
        logic setback;
        logic heat;
    } req_t;

    typedef struct packed {
        logic err_hi;
        logic err_lo;
        logic run_hi;
        logic run_lo;
    } contacts_t;

    typedef struct packed {
        logic       zones_at_setpoint;
        logic       zones_in_window;
        logic [1:0] drum_low;
        logic [1:0] drum_empty;
        logic       alarm;
    } plant_t;

    typedef enum logic [1:0] {PH_OFF, PH_WARM, PH_SOAK, PH_READY} phase_t;

endpackage

//--- hw/input_conditioner.sv
// two-stage synchroniser followed by a level filter for one pin
// assumes raw is asynchronous to aclk
`timescale 1ns/1ns
module input_conditioner
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pin and filtered level
    input  wire logic raw,
    output logic      level
);

    typedef struct packed {
        logic                                      s1;
        logic                                      s2;
        logic                                      lvl;
        logic [dispense_io_pkg::FILTER_CNT_W-1:0]  cnt;
    } cond_t;

    cond_t st_reg;
    cond_t st_next;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = raw;
        st_next.s2 = st_reg.s1;
        if (st_reg.s2 == st_reg.lvl)
            st_next.cnt = '0;
        else if (st_reg.cnt ==
                 dispense_io_pkg::FILTER_CNT_W'(dispense_io_pkg::FILTER_CYC - 1))
        begin
            st_next.lvl = st_reg.s2;
            st_next.cnt = '0;
        end
        else
            st_next.cnt = st_reg.cnt + 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign level = st_reg.lvl;

endmodule // input_conditioner

//--- hw/plc_discrete_io_supervisor.sv
// supervisor for the hard-wired controller interface of the dispenser
// assumes discrete pins are asynchronous, plant flags are on aclk
// Notes on behaviour
// - four request inputs, four state output contacts
// - takeover selects pin commands, locks local display
// - no automatic crossover under external command
// - heat request high starts it; setback request acts only with heat high
// - request low stops heat or leaves setback
// - run state two-bit encoding on outputs
// - error state two-bit encoding on outputs
// - contacts open unpowered, closed means asserted
// - warm-up then ready; pump only after ready
// - autostart latches at zone setpoint, pumps once ready
// - air motor locked until zones in window
// - configurable heat soak before air release
// - setback at least 20 F below setpoint, forced to 0 F when setpoint is 20 F or less
`timescale 1ns/1ns
module plc_discrete_io_supervisor
#(
    parameter int unsigned SOAK_UNIT_CYCLES = dispense_io_pkg::SOAK_UNIT_CYC
)
(
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite slave
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // discrete request pins, input terminal block
    input  wire dispense_io_pkg::req_t     pin_req,
    // discrete state contacts, output terminal block
    output dispense_io_pkg::contacts_t     contacts,
    // plant status from the zone control board
    input  wire dispense_io_pkg::plant_t   plant,
    // plant controls
    output logic                           heater_on,
    output logic                           setback_on,
    output logic                           pump_on,
    output logic                           air_motor_enable,
    output logic                           local_display_locked,
    output logic                           active_unit_b,
    // interrupt
    output logic                           irq
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic                               aw_v;
        logic [7:0]                         aw_addr;
        logic                               w_v;
        logic [31:0]                        w_data;
        logic [3:0]                         w_strb;
        logic                               b_v;
        logic [1:0]                         b_resp;
        logic                               r_v;
        logic [31:0]                        r_data;
        logic [1:0]                         r_resp;
        logic                               autostart;
        logic                               tandem_en;
        logic [2:0]                         local_cmd;
        logic [15:0]                        soak_min;
        logic [dispense_io_pkg::EV_W-1:0]   int_status;
        logic [dispense_io_pkg::EV_W-1:0]   int_en;
        logic [dispense_io_pkg::NUM_ZONES-1:0]
              [dispense_io_pkg::TEMP_W-1:0] setpoint;
        logic [dispense_io_pkg::NUM_ZONES-1:0]
              [dispense_io_pkg::TEMP_W-1:0] setback;
        dispense_io_pkg::phase_t            phase;
        logic [31:0]                        unit_cnt;
        logic [15:0]                        soak_cnt;
        logic                               pump_auto;
        logic                               active_b;
        logic                               alarm_d;
        logic                               empty_d;
        logic                               takeover_d;
        dispense_io_pkg::contacts_t         out;
        logic                               heat_o;
        logic                               setback_o;
        logic                               pump_o;
        logic                               air_o;
    } state_t;

    state_t st_reg;
    state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = data[i*8 +: 8];
        return res;
    endfunction

    function automatic logic [8:0] limit_setback(input logic [8:0] sp,
                                                 input logic [8:0] sb);
        logic [8:0] lim;
        lim = (sp > dispense_io_pkg::SETBACK_GAP) ?
              sp - dispense_io_pkg::SETBACK_GAP : 9'h000;
        return (sb > lim) ? lim : sb;
    endfunction

    function automatic logic is_temp(input logic [7:0] a);
        return a[7:4] == dispense_io_pkg::OFS_TEMP_BASE[7:4]
            && {1'b0, a[3:2]} < 3'(dispense_io_pkg::NUM_ZONES);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin conditioning
    dispense_io_pkg::req_t req;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_cond
            input_conditioner u_cond
            (
                .aclk    (aclk),
                .aresetn (aresetn),
                .raw     (pin_req[g]),
                .level   (req[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic        cmd_heat;
    logic        cmd_setback;
    logic        cmd_pump;
    logic        wr_fire;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic [dispense_io_pkg::EV_W-1:0] ev;
    logic [dispense_io_pkg::EV_W-1:0] clr;
    logic        active_empty;
    logic        other_empty;
    logic        release_air;
    logic [1:0]  zi;

    always_comb
    begin
        st_next = st_reg;
        ev      = '0;
        clr     = '0;
        wr_word = '0;
        rd_word = '0;
        rd_ok   = 1'b1;
        zi      = '0;

        // command source selection
        if (req.takeover)
        begin
            cmd_heat    = req.heat;
            cmd_setback = req.setback;
            cmd_pump    = req.pump;
        end
        else
        begin
            cmd_heat    = st_reg.local_cmd[0];
            cmd_setback = st_reg.local_cmd[1];
            cmd_pump    = st_reg.local_cmd[2];
        end

        // axi write channel capture
        if (s_axi_awvalid && !st_reg.aw_v && !st_reg.b_v)
        begin
            st_next.aw_v    = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_v && !st_reg.b_v)
        begin
            st_next.w_v    = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        wr_fire = st_reg.aw_v && st_reg.w_v && !st_reg.b_v;
        if (wr_fire)
        begin
            st_next.aw_v   = 1'b0;
            st_next.w_v    = 1'b0;
            st_next.b_v    = 1'b1;
            st_next.b_resp = dispense_io_pkg::RESP_OKAY;
            zi = st_reg.aw_addr[3:2];
            unique case (st_reg.aw_addr)
                dispense_io_pkg::OFS_CTRL:
                begin
                    wr_word = merge_bytes({30'h0, st_reg.tandem_en,
                                           st_reg.autostart},
                                          st_reg.w_data, st_reg.w_strb);
                    st_next.autostart = wr_word[0];
                    st_next.tandem_en = wr_word[1];
                end
                dispense_io_pkg::OFS_LOCAL:
                begin
                    wr_word = merge_bytes({29'h0, st_reg.local_cmd},
                                          st_reg.w_data, st_reg.w_strb);
                    if (!req.takeover)
                        st_next.local_cmd = wr_word[2:0];
                end
                dispense_io_pkg::OFS_SOAK:
                begin
                    wr_word = merge_bytes({16'h0, st_reg.soak_min},
                                          st_reg.w_data, st_reg.w_strb);
                    st_next.soak_min = wr_word[15:0];
                end
                dispense_io_pkg::OFS_INT_EN:
                begin
                    wr_word = merge_bytes(32'(st_reg.int_en),
                                          st_reg.w_data, st_reg.w_strb);
                    st_next.int_en = wr_word[dispense_io_pkg::EV_W-1:0];
                end
                dispense_io_pkg::OFS_INT_CLR:
                    clr = st_reg.w_data[dispense_io_pkg::EV_W-1:0];
                default:
                begin
                    if (is_temp(st_reg.aw_addr))
                    begin
                        wr_word = merge_bytes(
                            {7'h0, st_reg.setback[zi], 7'h0,
                             st_reg.setpoint[zi]},
                            st_reg.w_data, st_reg.w_strb);
                        st_next.setpoint[zi] =
                            wr_word[dispense_io_pkg::SP_LSB +: 9];
                        st_next.setback[zi] = limit_setback(
                            wr_word[dispense_io_pkg::SP_LSB +: 9],
                            wr_word[dispense_io_pkg::SB_LSB +: 9]);
                    end
                    else
                        st_next.b_resp = dispense_io_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.b_v && s_axi_bready)
            st_next.b_v = 1'b0;

        // axi read
        if (s_axi_arvalid && !st_reg.r_v)
        begin
            zi = s_axi_araddr[3:2];
            unique case (s_axi_araddr)
                dispense_io_pkg::OFS_CTRL:
                    rd_word = {30'h0, st_reg.tandem_en, st_reg.autostart};
                dispense_io_pkg::OFS_LOCAL:
                    rd_word = {29'h0, st_reg.local_cmd};
                dispense_io_pkg::OFS_SOAK:
                    rd_word = {16'h0, st_reg.soak_min};
                dispense_io_pkg::OFS_STATUS:
                    rd_word = {16'h0, st_reg.soak_cnt[7:0],
                               req.takeover, st_reg.active_b,
                               2'(st_reg.phase), st_reg.out};
                dispense_io_pkg::OFS_INT_STATUS:
                    rd_word = 32'(st_reg.int_status);
                dispense_io_pkg::OFS_INT_EN:
                    rd_word = 32'(st_reg.int_en);
                dispense_io_pkg::OFS_INT_CLR:
                    rd_word = '0;
                default:
                begin
                    if (is_temp(s_axi_araddr))
                        rd_word = {7'h0, st_reg.setback[zi],
                                   7'h0, st_reg.setpoint[zi]};
                    else
                        rd_ok = 1'b0;
                end
            endcase
            st_next.r_v    = 1'b1;
            st_next.r_data = rd_word;
            st_next.r_resp = rd_ok ? dispense_io_pkg::RESP_OKAY
                                   : dispense_io_pkg::RESP_SLVERR;
        end
        else if (st_reg.r_v && s_axi_rready)
            st_next.r_v = 1'b0;

        // heat phase sequence
        unique case (st_reg.phase)
            dispense_io_pkg::PH_OFF:
                if (cmd_heat && !cmd_setback)
                    st_next.phase = dispense_io_pkg::PH_WARM;
            dispense_io_pkg::PH_WARM:
                if (plant.zones_at_setpoint)
                begin
                    st_next.phase    = dispense_io_pkg::PH_SOAK;
                    st_next.unit_cnt = '0;
                    st_next.soak_cnt = '0;
                end
            dispense_io_pkg::PH_SOAK:
                if (!plant.zones_in_window)
                    st_next.phase = dispense_io_pkg::PH_WARM;
                else if (st_reg.soak_cnt >= st_reg.soak_min)
                begin
                    st_next.phase = dispense_io_pkg::PH_READY;
                    ev[dispense_io_pkg::EV_READY] = 1'b1;
                end
                else if (st_reg.unit_cnt == SOAK_UNIT_CYCLES - 1)
                begin
                    st_next.unit_cnt = '0;
                    st_next.soak_cnt = st_reg.soak_cnt + 1'b1;
                end
                else
                    st_next.unit_cnt = st_reg.unit_cnt + 1'b1;
            dispense_io_pkg::PH_READY:
                if (!plant.zones_in_window)
                    st_next.phase = dispense_io_pkg::PH_WARM;
        endcase
        if (!cmd_heat)
            st_next.phase = dispense_io_pkg::PH_OFF;
        else if (cmd_setback)
            st_next.phase = dispense_io_pkg::PH_WARM;

        // autostart latch, cleared with heat
        if (!cmd_heat || cmd_setback)
            st_next.pump_auto = 1'b0;
        else if (st_reg.autostart && plant.zones_at_setpoint)
            st_next.pump_auto = 1'b1;

        // air interlock and plant drives
        release_air = st_reg.phase == dispense_io_pkg::PH_READY
                   && plant.zones_in_window && cmd_heat
                   && !cmd_setback;
        st_next.air_o     = release_air;
        st_next.heat_o    = cmd_heat;
        st_next.setback_o = cmd_heat && cmd_setback;
        st_next.pump_o    = release_air
                         && (cmd_pump || st_reg.pump_auto);

        // crossover, only when the panel has control
        active_empty = plant.drum_empty[st_reg.active_b];
        other_empty  = plant.drum_empty[!st_reg.active_b];
        if (st_reg.tandem_en && !req.takeover && active_empty
            && !other_empty)
        begin
            st_next.active_b = !st_reg.active_b;
            ev[dispense_io_pkg::EV_CROSS] = 1'b1;
        end

        // run and error state contacts
        if (!st_reg.heat_o)
            {st_next.out.run_hi, st_next.out.run_lo} = 2'h0;
        else if (st_reg.pump_o)
            {st_next.out.run_hi, st_next.out.run_lo} = 2'h3;
        else if (st_reg.phase == dispense_io_pkg::PH_READY)
            {st_next.out.run_hi, st_next.out.run_lo} = 2'h2;
        else
            {st_next.out.run_hi, st_next.out.run_lo} = 2'h1;
        if (plant.alarm)
            {st_next.out.err_hi, st_next.out.err_lo} = 2'h3;
        else if (active_empty)
            {st_next.out.err_hi, st_next.out.err_lo} = 2'h2;
        else if (plant.drum_low[st_reg.active_b])
            {st_next.out.err_hi, st_next.out.err_lo} = 2'h1;
        else
            {st_next.out.err_hi, st_next.out.err_lo} = 2'h0;

        // events; a new event beats a clear in the same cycle
        st_next.alarm_d    = plant.alarm;
        st_next.empty_d    = active_empty;
        st_next.takeover_d = req.takeover;
        ev[dispense_io_pkg::EV_ALARM]    = plant.alarm && !st_reg.alarm_d;
        ev[dispense_io_pkg::EV_EMPTY]    = active_empty && !st_reg.empty_d;
        ev[dispense_io_pkg::EV_TAKEOVER] = req.takeover != st_reg.takeover_d;
        st_next.int_status = (st_reg.int_status & ~clr) | ev;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg          <= '0;
            st_reg.soak_min <= dispense_io_pkg::SOAK_MIN_RST;
            st_reg.setpoint <= {dispense_io_pkg::NUM_ZONES
                               {dispense_io_pkg::SP_RST}};
            st_reg.setback  <= {dispense_io_pkg::NUM_ZONES
                               {dispense_io_pkg::SB_RST}};
            st_reg.phase    <= dispense_io_pkg::PH_OFF;
        end
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready        = !st_reg.aw_v && !st_reg.b_v;
    assign s_axi_wready         = !st_reg.w_v && !st_reg.b_v;
    assign s_axi_bvalid         = st_reg.b_v;
    assign s_axi_bresp          = st_reg.b_resp;
    assign s_axi_arready        = !st_reg.r_v;
    assign s_axi_rvalid         = st_reg.r_v;
    assign s_axi_rdata          = st_reg.r_data;
    assign s_axi_rresp          = st_reg.r_resp;
    assign contacts             = st_reg.out;
    assign heater_on            = st_reg.heat_o;
    assign setback_on           = st_reg.setback_o;
    assign pump_on              = st_reg.pump_o;
    assign air_motor_enable     = st_reg.air_o;
    assign local_display_locked = st_reg.takeover_d;
    assign active_unit_b        = st_reg.active_b;
    assign irq                  = |(st_reg.int_status & st_reg.int_en);

endmodule // plc_discrete_io_supervisor

//--- bench/plc_model.sv
// controller model that drives the four request pins
// assumes cmd changes on aclk; pins feed the synchronisers
`timescale 1ns/1ns
module plc_model
(
    // clock
    input  wire logic                  aclk,
    // commanded levels and pins
    input  wire dispense_io_pkg::req_t cmd,
    output dispense_io_pkg::req_t      pin_req
);
    initial pin_req = '0;
    // pins follow cmd one edge later, no own crossover
    always @(posedge aclk)
        pin_req <= cmd;
endmodule // plc_model

//--- bench/sup_chk.sv
// timing checks on the supervisor ports
// assumes binding to plc_discrete_io_supervisor
`timescale 1ns/1ns
module sup_chk
(
    // watched ports
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire dispense_io_pkg::req_t      pin_req,
    input wire dispense_io_pkg::contacts_t contacts,
    input wire dispense_io_pkg::plant_t    plant,
    input wire logic                       heater_on,
    input wire logic                       pump_on,
    input wire logic                       air_motor_enable,
    input wire logic                       local_display_locked,
    input wire logic                       active_unit_b
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_out: assert property ($rose(aresetn) |-> contacts == 4'h0
        && !heater_on && !pump_on) else $error("reset outputs");
    a_run_pump: assert property (pump_on[*3] |=> contacts.run_hi
        && contacts.run_lo) else $error("run not 11");
    a_err_alarm: assert property (plant.alarm[*3] |=> contacts.err_hi
        && contacts.err_lo) else $error("alarm not shown");
    a_err_none: assert property ((plant[4:0] == 5'h00)[*3] |=>
        contacts[3:2] == 2'h0) else $error("false error");
    a_air_lock: assert property (air_motor_enable |->
        $past(plant.zones_in_window)) else $error("air out of window");
    a_lock_take: assert property (pin_req.takeover[*8] |-> ##2
        local_display_locked) else $error("takeover not applied");
    a_filter_glitch: assert property ((!pin_req.takeover)[*8] ##1
        pin_req.takeover ##1 !pin_req.takeover |-> (!local_display_locked)[*8])
        else $error("pulse passed filter");
    a_no_cross: assert property (local_display_locked[*2] |->
        $stable(active_unit_b)) else $error("crossover under takeover");
endmodule // sup_chk
bind plc_discrete_io_supervisor sup_chk chk (.*);

//--- bench/testbench.sv
// self-checking bench for the discrete io supervisor
// assumes 100 ns aclk; one soak minute shortened to 10 cycles
`timescale 1ns/1ns
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, heater_on, setback_on, pump_on, irq;
    logic air_motor_enable, local_display_locked, active_unit_b;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hF;
    dispense_io_pkg::req_t cmd = '0, pin_req;
    dispense_io_pkg::contacts_t contacts;
    dispense_io_pkg::plant_t plant = '0;
    int fail_count = 0, total_checks = 0, seed = 60;
    always #50 aclk = ~aclk;
    plc_model plc (.*);
    plc_discrete_io_supervisor #(.SOAK_UNIT_CYCLES(10)) dut (.*);
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [33:0] e, input logic [33:0] g);
        #1;
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [2:0] s;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            s = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge aclk);
            if (s[2]) s_axi_awvalid <= 1'b0;
            if (s[1]) s_axi_wvalid <= 1'b0;
        end
        while (!s[0]);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] r = dispense_io_pkg::RESP_OKAY);
        logic [35:0] s;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do
        begin
            @(negedge aclk);
            s = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (s[35]) s_axi_arvalid <= 1'b0;
        end
        while (!s[34]);
        s_axi_rready <= 1'b0;
        chk("read", {r, e}, s[33:0]);
    endtask
    function automatic logic [1:0] exp_err(dispense_io_pkg::plant_t p);
        return p.alarm ? 2'h3 : p.drum_empty[0] ? 2'h2 : {1'b0, p.drum_low[0]};
    endfunction
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #3_000_000;
        fail_count++;
        finish_test();
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h08, 32'h2D);
        rd(8'h20, {7'h00, dispense_io_pkg::SB_RST, 7'h00,
            dispense_io_pkg::SP_RST});
        rd(8'hFC, 32'h0, dispense_io_pkg::RESP_SLVERR);
        wr(8'h20, 32'h017C017C);
        rd(8'h20, 32'h0168017C);
        wr(8'h08, 32'h1);
        wr(8'h14, 32'h4);
        cmd <= 4'b1000;
        @(posedge aclk);
        cmd <= 4'b0000;
        repeat (12) @(posedge aclk);
        $display("regs done");
        cmd <= 4'b1001;
        repeat (12) @(posedge aclk);
        chk("locked", 1, local_display_locked);
        chk("heater", 1, heater_on);
        plant <= 7'h60;
        for (int i = 0; i < 300 && !air_motor_enable; i++) @(posedge aclk);
        repeat (3) @(posedge aclk);
        chk("air", 1, air_motor_enable);
        chk("ready", 32'h2, {pump_on, contacts});
        chk("irq", 1, irq);
        wr(8'h14, 32'h0);
        chk("irq masked", 0, irq);
        wr(8'h14, 32'h4);
        chk("irq enabled", 1, irq);
        wr(8'h18, 32'h4);
        chk("irq cleared", 0, irq);
        cmd <= 4'b1101;
        for (int i = 0; i < 50 && !pump_on; i++) @(posedge aclk);
        repeat (4) @(posedge aclk);
        chk("pumping", 32'h3, contacts);
        $display("pump done");
        for (int i = 0; i < 12; i++)
        begin
            plant <= 7'h60 | (i == 0 ? 7'h01 : 7'($random(seed)) & 7'h1F);
            repeat (6) @(posedge aclk);
            chk("error bits", exp_err(plant), contacts[3:2]);
        end
        plant <= 7'h60;
        cmd <= 4'b1011;
        repeat (12) @(posedge aclk);
        chk("setback", 32'h1, {air_motor_enable, setback_on});
        cmd <= 4'b1000;
        repeat (12) @(posedge aclk);
        chk("heat off", 32'h0, {heater_on, setback_on, contacts});
        $display("shutdown done");
        finish_test();
    end
endmodule // testbench
